// ==== hw/mct_ch5.sv ====
/*
 * Channel-5 pin A control, its general register A and status flags,
 * plus the six per-channel interrupt enable registers, behind APB.
 * Assumes the counter, prescaler and the other channels' flag logic
 * sit outside and feed count_value_i, count_en_i and ext_flags_i.
 */
`timescale 1ns/1ps

module mct_ch5
    import mct_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // counter side
    input wire logic [15:0] count_value_i,
    input wire logic count_en_i,
    input wire logic count_up_i,
    input wire logic phase_mode_i,
    input wire logic reg_b_match_i,
    // flags of channels 0 to 4
    input wire mct_evt_s [NUM_CH-2:0] ext_flags_i,
    // pin a of channel 5
    input wire logic cc_pin_a_ch5_i,
    output logic cc_pin_a_ch5_o,
    output logic cc_pin_a_ch5_oe_o,
    // requests
    output logic adc_start_o,
    output mct_evt_s [NUM_CH-1:0] irq_req_o
);

    // ========================================================
    // declarations
    // ========================================================
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    mct_apb_req_s req;
    logic setup;
    logic access;
    logic wr_fire;
    logic hit_io;
    logic hit_gra;
    logic hit_status;
    logic hit_count;
    logic status_wr;
    logic status_rd;
    logic [31:0] rd_word;

    logic [3:0] io_control_ch5_r;
    logic [3:0] io_control_ch5_nxt;
    logic io_load_r;
    logic io_load_nxt;
    logic [15:0] general_reg_a_ch5_r;
    logic [15:0] general_reg_a_ch5_nxt;
    logic [15:0] last_count_r;
    logic [15:0] last_count_nxt;
    mct_evt_s flags_r;
    mct_evt_s flags_nxt;
    mct_evt_s seen_r;
    mct_evt_s seen_nxt;
    logic adc_r;
    logic adc_nxt;

    logic cmp_match;
    logic capture;
    logic ov_evt;
    logic uf_evt;
    logic a_evt;
    mct_evt_s set_v;
    mct_evt_s clr_v;
    logic [7:0] status_v;

    logic [NUM_CH-1:0] ier_wr;
    logic [7:0] ier_val [NUM_CH];
    mct_evt_s [NUM_CH-1:0] all_flags;
    mct_evt_s [NUM_CH-1:0] req_v;

    // ========================================================
    // address decode
    // ========================================================
    function automatic logic ier_hit(input logic [11:0] a, input int ch);
        logic [11:0] off;
        off = OFF_IER_BASE + 12'(ch) * OFF_IER_STEP;
        return a == off;
    endfunction

    function automatic logic addr_valid(input logic [11:0] a);
        logic hit;
        hit = (a == OFF_IO_CTRL) || (a == OFF_GRA) ||
              (a == OFF_STATUS) || (a == OFF_COUNT);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            hit = hit | ier_hit(a, ch);
        end
        return hit;
    endfunction

    assign req.addr = paddr_i;
    assign req.write = pwrite_i;
    assign req.wdata = pwdata_i;

    // one decoder feeds the read mux, the write strobes and the marks
    assign hit_io = (req.addr == OFF_IO_CTRL);
    assign hit_gra = (req.addr == OFF_GRA);
    assign hit_status = (req.addr == OFF_STATUS);
    assign hit_count = (req.addr == OFF_COUNT);

    // answer comes in the first access cycle, no wait states
    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i & pready_r;
    // an unmapped write is refused and stores nothing
    assign wr_fire = access & req.write & addr_valid(req.addr);
    assign status_wr = wr_fire & hit_status;
    // marked at setup, from the same flags that go into prdata
    assign status_rd = setup & ~req.write & hit_status;

    // ========================================================
    // events of channel 5
    // ========================================================
    assign cmp_match = count_en_i & ~mct_is_capture(io_control_ch5_r) &
                       (count_value_i == general_reg_a_ch5_r);
    assign ov_evt = count_en_i & (last_count_r == COUNT_MAX) &
                    (count_value_i == COUNT_MIN);
    assign uf_evt = count_en_i & phase_mode_i &
                    (last_count_r == COUNT_MIN) &
                    (count_value_i == COUNT_MAX);
    assign a_evt = cmp_match | capture;

    assign status_v = {count_up_i, 1'b1, 6'(flags_r)};

    // ========================================================
    // apb read path and handshake
    // ========================================================
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_io) begin
            rd_word = {28'h000_0000, io_control_ch5_r};
        end else if (hit_gra) begin
            rd_word = {16'h0000, general_reg_a_ch5_r};
        end else if (hit_status) begin
            rd_word = {24'h00_0000, status_v};
        end else if (hit_count) begin
            rd_word = {16'h0000, count_value_i};
        end
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (ier_hit(req.addr, ch)) begin
                rd_word = {24'h00_0000, ier_val[ch]};
            end
        end
    end

    always_comb begin
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        if (setup) begin
            // unmapped reads return zero, writes read back nothing
            prdata_nxt = 32'h0000_0000;
            pslverr_nxt = ~addr_valid(req.addr);
            if (!req.write) begin
                prdata_nxt = rd_word;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ========================================================
    // control registers of channel 5
    // ========================================================
    always_comb begin
        io_control_ch5_nxt = io_control_ch5_r;
        io_load_nxt = 1'b0;
        general_reg_a_ch5_nxt = general_reg_a_ch5_r;
        last_count_nxt = last_count_r;
        if (wr_fire && hit_io) begin
            io_control_ch5_nxt = req.wdata[3:0];
            io_load_nxt = 1'b1;
        end
        if (wr_fire && hit_gra) begin
            general_reg_a_ch5_nxt = req.wdata[15:0];
        end
        // hardware capture wins over a software write
        if (capture) begin
            general_reg_a_ch5_nxt = count_value_i;
        end
        if (count_en_i) begin
            last_count_nxt = count_value_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            io_control_ch5_r <= IO_CTRL_RESET;
            io_load_r <= 1'b1;
            general_reg_a_ch5_r <= GRA_RESET;
            last_count_r <= COUNT_MIN;
        end else begin
            io_control_ch5_r <= io_control_ch5_nxt;
            io_load_r <= io_load_nxt;
            general_reg_a_ch5_r <= general_reg_a_ch5_nxt;
            last_count_r <= last_count_nxt;
        end
    end

    // ========================================================
    // status flags of channel 5
    // ========================================================
    always_comb begin
        set_v = mct_evt_s'(FLAGS_RESET);
        set_v.ov = ov_evt;
        set_v.uf = uf_evt;
        set_v.b = reg_b_match_i;
        set_v.a = a_evt;
        clr_v = mct_evt_s'(FLAGS_RESET);
        // a zero clears only a flag read as one before
        if (status_wr) begin
            clr_v = mct_evt_s'(seen_r & ~req.wdata[5:0]);
        end
        // set beats a clear landing in the same cycle
        flags_nxt = mct_evt_s'((flags_r & ~clr_v) | set_v);
        adc_nxt = a_evt & ier_val[OWN_CH][IER_ADC_BIT];
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flags_r <= mct_evt_s'(FLAGS_RESET);
            adc_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            adc_r <= adc_nxt;
        end
    end

    // ========================================================
    // read marks of channel 5 flags
    // ========================================================
    always_comb begin
        seen_nxt = seen_r;
        // a cleared flag must be read as one again first
        if (status_wr) begin
            seen_nxt = mct_evt_s'(seen_r & ~clr_v);
        end
        if (status_rd) begin
            seen_nxt = mct_evt_s'(seen_r | flags_r);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            seen_r <= mct_evt_s'(FLAGS_RESET);
        end else begin
            seen_r <= seen_nxt;
        end
    end

    // ========================================================
    // pin a
    // ========================================================
    mct_pin_a u_pin_a (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sel_i(io_control_ch5_r),
        .load_i(io_load_r),
        .match_i(cmp_match),
        .pin_i(cc_pin_a_ch5_i),
        .pin_o(cc_pin_a_ch5_o),
        .pin_oe_o(cc_pin_a_ch5_oe_o),
        .capture_o(capture)
    );

    // ========================================================
    // interrupt enables, one per channel
    // ========================================================
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ier
        if (ch == OWN_CH) begin : g_own
            assign all_flags[ch] = flags_r;
        end else begin : g_ext
            assign all_flags[ch] = ext_flags_i[ch];
        end
        assign ier_wr[ch] = wr_fire & ier_hit(req.addr, ch);
        mct_irq_gate #(
            .WMASK(mct_ier_mask(ch))
        ) u_gate (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .wr_i(ier_wr[ch]),
            .wdata_i(req.wdata[7:0]),
            .value_o(ier_val[ch]),
            .flags_i(all_flags[ch]),
            .req_o(req_v[ch])
        );
    end

    // ========================================================
    // outputs
    // ========================================================
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign adc_start_o = adc_r;
    assign irq_req_o = req_v;

endmodule // mct_ch5

// ==== include/mct_pkg.sv ====
/*
 * Shared constants, carriers and helpers of the channel-5 pin and
 * interrupt enable block.
 * Assumes a 12-bit APB byte address and a 16-bit counter outside.
 */
package mct_pkg;

    // ========================================================
    // register map, byte addresses
    // ========================================================
    localparam logic [11:0] OFF_IO_CTRL = 12'h000;
    localparam logic [11:0] OFF_GRA = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_COUNT = 12'h00c;
    localparam logic [11:0] OFF_IER_BASE = 12'h010;
    localparam logic [11:0] OFF_IER_STEP = 12'h004;

    // ========================================================
    // sizes
    // ========================================================
    localparam int NUM_CH = 6;
    localparam int OWN_CH = 5;

    // ========================================================
    // io control select fields
    // ========================================================
    localparam int SEL_CAP_BIT = 3;
    localparam int SEL_INIT_BIT = 2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam int EDGE_BOTH_BIT = 1;

    // ========================================================
    // interrupt enable and status fields
    // ========================================================
    localparam int IER_ADC_BIT = 7;
    localparam int IER_FIXED_BIT = 6;
    localparam logic [7:0] IER_FIXED_ONES = 8'h40;
    localparam logic [7:0] IER_MASK_ALL = 8'h93;
    localparam logic [7:0] IER_MASK_UF = 8'h20;
    localparam logic [7:0] IER_MASK_CD = 8'h0c;
    localparam int ST_DIR_BIT = 7;
    localparam int ST_FIXED_BIT = 6;

    // ========================================================
    // reset values and counter limits
    // ========================================================
    localparam logic [3:0] IO_CTRL_RESET = 4'h0;
    localparam logic [15:0] GRA_RESET = 16'h0000;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_MIN = 16'h0000;

    // flag / request group of one channel, bit order as in the registers
    typedef struct packed {
        logic uf;
        logic ov;
        logic d;
        logic c;
        logic b;
        logic a;
    } mct_evt_s;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } mct_apb_req_s;

    function automatic logic mct_is_capture(input logic [3:0] sel);
        return sel[SEL_CAP_BIT];
    endfunction

    // channels 0 and 3 own registers c and d, the others underflow
    function automatic logic mct_has_cd(input int ch);
        return (ch == 0) || (ch == 3);
    endfunction

    function automatic logic [7:0] mct_ier_mask(input int ch);
        return mct_has_cd(ch) ? (IER_MASK_ALL | IER_MASK_CD)
                              : (IER_MASK_ALL | IER_MASK_UF);
    endfunction

endpackage

// ==== hw/mct_irq_gate.sv ====
/*
 * Interrupt enable register of one channel and its request gating.
 * Assumes write strobes come from the APB slave in the top.
 */
`timescale 1ns/1ps
module mct_irq_gate
    import mct_pkg::*;
#(
    parameter logic [7:0] WMASK = IER_MASK_ALL
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register access
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] value_o,
    // flags in, requests out
    input wire mct_evt_s flags_i,
    output mct_evt_s req_o
);
    logic [7:0] en_r;
    logic [7:0] en_nxt;
    mct_evt_s req_r;
    mct_evt_s req_nxt;

    always_comb begin
        en_nxt = en_r;
        if (wr_i) begin
            // reserved bits never store
            en_nxt = wdata_i & WMASK;
        end
        // level request, drops with flag or enable
        req_nxt = mct_evt_s'(flags_i & en_r[5:0]);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            en_r <= IER_RESET;
            req_r <= mct_evt_s'(FLAGS_RESET);
        end else begin
            en_r <= en_nxt;
            req_r <= req_nxt;
        end
    end

    assign value_o = en_r | IER_FIXED_ONES;
    assign req_o = req_r;

endmodule // mct_irq_gate

// ==== hw/mct_pin_a.sv ====
/*
 * Pin A of channel 5: compare output drive and capture edge detect.
 * Assumes the pin input is synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
module mct_pin_a
    import mct_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control
    input wire logic [3:0] sel_i,
    input wire logic load_i,
    input wire logic match_i,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic capture_o
);
    typedef enum logic [2:0] {
        MODE_OFF = 3'b001,
        MODE_CMP = 3'b010,
        MODE_CAP = 3'b100
    } mct_mode_e;

    mct_mode_e mode_r;
    mct_mode_e mode_nxt;
    logic lvl_r;
    logic lvl_nxt;
    logic prev_r;
    logic rise;
    logic fall;

    assign rise = pin_i & ~prev_r;
    assign fall = ~pin_i & prev_r;

    always_comb begin
        lvl_nxt = lvl_r;
        if (mct_is_capture(sel_i)) begin
            mode_nxt = MODE_CAP;
        end else if (sel_i[1:0] == ACT_NONE) begin
            mode_nxt = MODE_OFF;
        end else begin
            mode_nxt = MODE_CMP;
        end
        // a fresh setting wins over a match in the same cycle
        if (load_i) begin
            lvl_nxt = sel_i[SEL_INIT_BIT];
        end else if (match_i && mode_r == MODE_CMP) begin
            case (sel_i[1:0])
                ACT_LOW: lvl_nxt = 1'b0;
                ACT_HIGH: lvl_nxt = 1'b1;
                ACT_TOGGLE: lvl_nxt = ~lvl_r;
                default: lvl_nxt = lvl_r;
            endcase
        end
    end

    always_comb begin
        case (mode_r)
            MODE_CAP: begin
                if (sel_i[EDGE_BOTH_BIT]) begin
                    capture_o = rise | fall;
                end else if (sel_i[1:0] == EDGE_FALL) begin
                    capture_o = fall;
                end else begin
                    capture_o = rise;
                end
            end
            default: capture_o = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_r <= MODE_OFF;
            lvl_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            lvl_r <= lvl_nxt;
            prev_r <= pin_i;
        end
    end

    assign pin_o = lvl_r;
    assign pin_oe_o = (mode_r == MODE_CMP);

endmodule // mct_pin_a

// ==== testbench/mct_ch5_chk.sv ====
/* port-level checker of mct_ch5.
   assumes it is bound to every mct_ch5 instance. */
`timescale 1ns/1ps
module mct_ch5_chk
    import mct_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic adc_start_o,
    input wire mct_evt_s [NUM_CH-2:0] ext_flags_i,
    input wire mct_evt_s [NUM_CH-1:0] irq_req_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // =====
    // bus
    // =====
    a_ready_after_setup: assert property (
        psel_i && !penable_i |=> pready_o) else $error("pready late");
    a_ready_single: assert property (
        pready_o |=> !pready_o) else $error("pready too long");
    a_err_with_ready: assert property (
        pslverr_o |-> pready_o) else $error("pslverr alone");
    // =====
    // requests
    // =====
    a_adc_one_cycle: assert property (
        adc_start_o |=> !adc_start_o) else $error("adc pulse too long");
    a_flag_a_gate: assert property (
        !ext_flags_i[0].a |=> !irq_req_o[0].a) else $error("irq a no flag");
    a_ovf_gate: assert property (
        !ext_flags_i[1].ov [*2] |-> !irq_req_o[1].ov)
        else $error("irq ov no flag");
    a_uf_reserved: assert property (
        !irq_req_o[0].uf && !irq_req_o[3].uf) else $error("uf on ch0/3");
    a_cd_reserved: assert property (
        (irq_req_o[1][3:2] | irq_req_o[2][3:2] | irq_req_o[4][3:2]
         | irq_req_o[5][3:2]) == 2'h0) else $error("c/d request");
    a_reset_quiet: assert property (
        $past(rst_i) |-> !pready_o && !adc_start_o && irq_req_o == '0)
        else $error("busy after reset");
endmodule // mct_ch5_chk

bind mct_ch5 mct_ch5_chk u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .adc_start_o(adc_start_o),
    .ext_flags_i(ext_flags_i),
    .irq_req_o(irq_req_o)
);

// ==== testbench/mct_far_model.sv ====
/* far side: other party of pin a and the a/d start input.
   assumes the bench names the level it wants on the pin. */
`timescale 1ns/1ps
module mct_far_model (
    // clock
    input wire logic sys_clk_i,
    // pin and converter
    input wire logic drv_i,
    input wire logic drv_oe_i,
    input wire logic want_i,
    input wire logic adc_req_i,
    output logic wire_o,
    output int starts_o
);
    int starts_r = 0;
    // the block owns the wire while it drives, we drive otherwise
    assign wire_o = drv_oe_i ? drv_i : want_i;
    assign starts_o = starts_r;
    always @(posedge sys_clk_i) begin
        if (adc_req_i === 1'b1) begin
            starts_r <= starts_r + 1;
        end
    end
endmodule // mct_far_model

// ==== testbench/timer_pin_io_and_irq_enable_bench.sv ====
/* self-checking bench of mct_ch5 with the far-side model.
   assumes a 40 MHz clock and the apb answer of the hand-over. */
`timescale 1ns/1ps
module timer_pin_io_and_irq_enable_bench;
    import mct_pkg::*;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic err;
    } mct_row_s;
    logic clk;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, pin_o, pin_oe, pin_i, adc;
    logic [15:0] cnt = 16'h0000, gra;
    logic cnt_en = 1'b0, phase = 1'b0, bmatch = 1'b0, want = 1'b0, ep;
    mct_evt_s [4:0] ext = '0;
    mct_evt_s [5:0] irq;
    int adc_n, failures = 0, check_count = 0, cycles = 0;
    mct_row_s rows [9] = '{
        '{12'h010, 32'hff, 32'hdf, 1'b0}, '{12'h014, 32'hff, 32'hf3, 1'b0},
        '{12'h018, 32'hff, 32'hf3, 1'b0}, '{12'h01c, 32'hff, 32'hdf, 1'b0},
        '{12'h020, 32'hff, 32'hf3, 1'b0}, '{12'h024, 32'hff, 32'hf3, 1'b0},
        '{12'h004, 32'habcd, 32'habcd, 1'b0}, '{12'h000, 32'h5, 32'h5, 1'b0},
        '{12'h100, 32'h7, 32'h0, 1'b1}};

    mct_ch5 u_mct_ch5 (
        .sys_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .count_value_i(cnt), .count_en_i(cnt_en), .count_up_i(1'b1),
        .phase_mode_i(phase), .reg_b_match_i(bmatch), .ext_flags_i(ext),
        .cc_pin_a_ch5_i(pin_i), .cc_pin_a_ch5_o(pin_o),
        .cc_pin_a_ch5_oe_o(pin_oe), .adc_start_o(adc), .irq_req_o(irq));
    mct_far_model u_mct_far_model (
        .sys_clk_i(clk), .drv_i(pin_o), .drv_oe_i(pin_oe), .want_i(want),
        .adc_req_i(adc), .wire_o(pin_i), .starts_o(adc_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // =====
    // helpers
    // =====
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // one counter value taken, then let flag and pin settle
    task automatic tick(input logic [15:0] v);
        cnt <= v;
        cnt_en <= 1'b1;
        @(posedge clk);
        cnt_en <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // run is about 270 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    // =====
    // tests
    // =====
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, rows[i].wdata);
            apb(rows[i].addr, 1'b0, 32'h0);
            chk(rd, rows[i].rdata);
            chk({31'h0, er}, {31'h0, rows[i].err});
        end
        $display("register table done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < NUM_CH; c++) begin
            apb(OFF_IER_BASE + 12'(4 * c), 1'b0, 32'h0);
            chk(rd, 32'h40);
        end
        apb(OFF_IO_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("reset values done");
        apb(12'h024, 1'b1, 32'h80);
        apb(OFF_GRA, 1'b1, 32'h10);
        for (int s = 0; s < 8; s++) begin
            apb(OFF_IO_CTRL, 1'b1, 32'(s));
            repeat (2) @(posedge clk);
            chk({31'h0, pin_oe}, {31'h0, s[1:0] != 2'h0});
            if (s[1:0] != 2'h0) chk({31'h0, pin_o}, {31'h0, s[2]});
            tick(16'h0010);
            ep = (s[1:0] == 2'h1) ? 1'b0 : (s[1:0] == 2'h2) ? 1'b1 : ~s[2];
            if (s[1:0] != 2'h0) chk({31'h0, pin_o}, {31'h0, ep});
        end
        $display("compare codes done");
        gra = 16'h0010;
        // code 15: bit 2 must not matter in capture mode
        for (int s = 8; s < 12; s++) begin
            apb(OFF_IO_CTRL, 1'b1, (s == 11) ? 32'hf : 32'(s));
            repeat (2) @(posedge clk);
            cnt <= 16'h1200 + 16'(s);
            want <= 1'b1;
            repeat (3) @(posedge clk);
            if (s != 9) gra = 16'h1200 + 16'(s);
            apb(OFF_GRA, 1'b0, 32'h0);
            chk(rd, {16'h0, gra});
            cnt <= 16'h3400 + 16'(s);
            want <= 1'b0;
            repeat (3) @(posedge clk);
            if (s != 8) gra = 16'h3400 + 16'(s);
            apb(OFF_GRA, 1'b0, 32'h0);
            chk(rd, {16'h0, gra});
        end
        chk(32'(adc_n), 32'd14);
        apb(12'h024, 1'b1, 32'h00);
        want <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(adc_n), 32'd14);
        $display("capture edges done");
        apb(12'h024, 1'b1, 32'hb3);
        tick(16'hffff);
        tick(16'h0000);
        phase <= 1'b1;
        tick(16'hffff);
        bmatch <= 1'b1;
        @(posedge clk);
        bmatch <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(irq[5]), 32'h33);
        apb(OFF_STATUS, 1'b0, 32'h0);
        chk(rd, 32'hf3);
        apb(OFF_STATUS, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq[5]), 32'h0);
        $display("channel five flags done");
        apb(12'h010, 1'b1, 32'hff);
        apb(12'h014, 1'b1, 32'hff);
        apb(12'h01c, 1'b1, 32'h0c);
        apb(12'h020, 1'b1, 32'h10);
        ext <= {5{6'h3f}};
        repeat (2) @(posedge clk);
        chk(32'(irq[0]), 32'h1f);
        chk(32'(irq[1]), 32'h33);
        chk(32'(irq[2]), 32'h00);
        chk(32'(irq[3]), 32'h0c);
        chk(32'(irq[4]), 32'h10);
        ext <= '0;
        repeat (2) @(posedge clk);
        chk(32'(irq[4:0]), 32'h0);
        $display("other channels done");
        tally_and_finish();
    end
endmodule // timer_pin_io_and_irq_enable_bench
